// *** alrm_top.sv ***
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "alrm_cfg.svh"
module alrm_top import alrm_pkg::*; (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic [3:0]  I_REF_FREQ_ALM,
    input  wire logic [3:0]  I_REF_SIG_LOSS,
    input  wire logic [3:0]  I_REF_ACT_ALM,
    input  wire logic [14:0] I_PLL_STATE,
    input  wire logic        I_APLL_LOCKED,
    input  wire logic [7:0]  I_AWADDR,
    input  wire logic        I_AWVALID,
    output logic             O_AWREADY,
    input  wire logic [31:0] I_WDATA,
    input  wire logic [3:0]  I_WSTRB,
    input  wire logic        I_WVALID,
    output logic             O_WREADY,
    output logic [1:0]       O_BRESP,
    output logic             O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic [7:0]  I_ARADDR,
    input  wire logic        I_ARVALID,
    output logic             O_ARREADY,
    output logic [31:0]      O_RDATA,
    output logic [1:0]       O_RRESP,
    output logic             O_RVALID,
    input  wire logic        I_RREADY,
    output logic [3:0]       O_GPIO_OUT,
    output logic [3:0]       O_GPIO_OE
);
    // register bus: AXI4-Lite slave, one write and one read in flight

    logic        aw_got_q;
    logic        w_got_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] wr_data_q;
    logic [3:0]  wr_strb_q;
    logic        wr_fire_w;
    logic        aw_hs_w;
    logic        w_hs_w;
    logic        ar_hs_w;
    logic        wr_map_w;
    logic        rd_map_w;
    logic [31:0] rd_word_w;

    logic        ctrl_q;
    alrm_vec_t   alert_en_q;
    logic [8:0]  gcfg_q [`ALRM_NUM_GPIO];

    alrm_vec_t   live_w;
    alrm_vec_t   clr_w;
    alrm_blk_t   blk_clr_w;
    logic        alert_w;

    alrm_stk_if  stk ();

    function automatic logic is_gpio(input logic [7:0] a);
        return a[7:4] == `ALRM_ADDR_GPIO0 >> 4 && a[1:0] == 2'b00;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return (a[7:5] == 3'b000 && a[1:0] == 2'b00) || is_gpio(a);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // live alarm vector; reference monitor i owns bits 3i..3i+2
    genvar gi;
    generate
        for (gi = 0; gi < `ALRM_NUM_REF; gi++) begin : g_ref
            assign live_w[3*gi]   = I_REF_FREQ_ALM[gi];
            assign live_w[3*gi+1] = I_REF_SIG_LOSS[gi];
            assign live_w[3*gi+2] = I_REF_ACT_ALM[gi];
        end
        for (gi = 0; gi < `ALRM_NUM_PLL; gi++) begin : g_pll
            // last loop (index 4) is the system phase loop
            wire alrm_pll_st_t st_w = alrm_pll_st_t'(I_PLL_STATE[3*gi +: 3]);
            // stickies fire on entering and on leaving holdover or locked, via the level change
            assign live_w[`ALRM_PLL_BASE+2*gi]   = st_w == ALRM_PLL_HOLDOVER;
            assign live_w[`ALRM_PLL_BASE+2*gi+1] = st_w == ALRM_PLL_LOCKED && I_APLL_LOCKED;
        end
    endgenerate

    assign aw_hs_w   = I_AWVALID && O_AWREADY;
    assign w_hs_w    = I_WVALID && O_WREADY;
    assign ar_hs_w   = I_ARVALID && O_ARREADY;
    assign wr_fire_w = aw_got_q && w_got_q && !O_BVALID;
    assign wr_map_w  = is_mapped(wr_addr_q);
    assign rd_map_w  = is_mapped(I_ARADDR);

    // clears are one-cycle pulses; a write of ones clears those bits only
    assign clr_w     = (wr_fire_w && wr_addr_q == `ALRM_ADDR_CLR) ?
                       alrm_vec_t'(merge(32'h0, wr_data_q, wr_strb_q)) : '0;
    assign blk_clr_w = (wr_fire_w && wr_addr_q == `ALRM_ADDR_BLK_CLR) ?
                       alrm_blk_t'(merge(32'h0, wr_data_q, wr_strb_q)) : '0;

    assign stk.live     = live_w;
    assign stk.clr      = clr_w;
    assign stk.blk_clr  = blk_clr_w;
    assign stk.alert_en = alert_en_q;
    assign stk.glob_en  = ctrl_q;

    alrm_sticky_bank u_bank (
        .i_clk (I_CLK),
        .i_rst (I_RST),
        .bus   (stk.bank)
    );

    // alert waits on both individual and block stickies; negation is one cycle,
    // well inside the allowed lag, but software must still treat it as a level
    assign alert_w = |(stk.sticky & alert_en_q) | |stk.blk_sticky;

    assign rd_word_w =
        I_ARADDR == `ALRM_ADDR_CTRL     ? {31'h0, ctrl_q} :
        I_ARADDR == `ALRM_ADDR_LIVE     ? {10'h0, live_w} :
        I_ARADDR == `ALRM_ADDR_STICKY   ? {10'h0, stk.sticky} :
        I_ARADDR == `ALRM_ADDR_ALERT_EN ? {10'h0, alert_en_q} :
        I_ARADDR == `ALRM_ADDR_BLK_STK  ? {23'h0, stk.blk_sticky} :
        I_ARADDR == `ALRM_ADDR_PLL_ST   ? {17'h0, I_PLL_STATE} :
        is_gpio(I_ARADDR)               ? {23'h0, gcfg_q[I_ARADDR[3:2]]} :
        32'h0;

    // write channel: address and data are taken in either order
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            O_BVALID  <= 1'b0;
            O_BRESP   <= `ALRM_RESP_OKAY;
        end else begin
            O_AWREADY <= !aw_got_q && !aw_hs_w && !O_BVALID;
            O_WREADY  <= !w_got_q && !w_hs_w && !O_BVALID;
            if (aw_hs_w) begin
                aw_got_q <= 1'b1;
            end
            if (w_hs_w) begin
                w_got_q <= 1'b1;
            end
            if (wr_fire_w) begin
                O_BVALID <= 1'b1;
                O_BRESP  <= wr_map_w ? `ALRM_RESP_OKAY : `ALRM_RESP_SLVERR;
            end else if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (aw_hs_w) begin
            wr_addr_q <= I_AWADDR;
        end
        if (w_hs_w) begin
            wr_data_q <= I_WDATA;
            wr_strb_q <= I_WSTRB;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            ctrl_q     <= `ALRM_CTRL_RST;
            alert_en_q <= `ALRM_ALERT_EN_RST;
        end else if (wr_fire_w) begin
            if (wr_addr_q == `ALRM_ADDR_CTRL && wr_strb_q[0]) begin
                ctrl_q <= wr_data_q[`ALRM_CTRL_GEN_BIT];
            end
            if (wr_addr_q == `ALRM_ADDR_ALERT_EN) begin
                alert_en_q <= alrm_vec_t'(merge({10'h0, alert_en_q}, wr_data_q, wr_strb_q));
            end
        end
    end

    // read channel: data latched at the address handshake
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h0;
            O_RRESP   <= `ALRM_RESP_OKAY;
        end else begin
            O_ARREADY <= !ar_hs_w && !(O_RVALID && !I_RREADY);
            if (ar_hs_w) begin
                O_RVALID <= 1'b1;
                O_RDATA  <= rd_map_w ? rd_word_w : 32'h0;
                O_RRESP  <= rd_map_w ? `ALRM_RESP_OKAY : `ALRM_RESP_SLVERR;
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end

    // per-pin GPIO alarm routing
    generate
        for (gi = 0; gi < `ALRM_NUM_GPIO; gi++) begin : g_gpio
            wire alrm_gmode_t mode_w = alrm_gmode_t'(gcfg_q[gi][`ALRM_GCFG_MODE_LSB +: 2]);
            wire logic        inv_w  = gcfg_q[gi][`ALRM_GCFG_INV_BIT];
            wire logic [4:0]  sel_w  = gcfg_q[gi][`ALRM_GCFG_SEL_LSB +: 5];
            wire logic        ok_w   = sel_w < 5'(`ALRM_NUM_ALM);
            wire logic        one_w  = ok_w && (gcfg_q[gi][`ALRM_GCFG_STK_BIT] ? stk.sticky[sel_w] : live_w[sel_w]);
            wire logic        los_w  = live_w[3*sel_w[1:0]+1];
            wire logic        val_w  = mode_w == ALRM_GPIO_ALERT   ? alert_w :
                                       mode_w == ALRM_GPIO_SINGLE  ? one_w :
                                       mode_w == ALRM_GPIO_SIGLOSS ? los_w : 1'b0;

            always_ff @(posedge I_CLK) begin
                if (I_RST) begin
                    gcfg_q[gi] <= `ALRM_GCFG_RST;
                end else if (wr_fire_w && wr_addr_q == `ALRM_ADDR_GPIO0 + 8'(4*gi)) begin
                    gcfg_q[gi] <= 9'(merge({23'h0, gcfg_q[gi]}, wr_data_q, wr_strb_q));
                end
            end

            always_ff @(posedge I_CLK) begin
                if (I_RST) begin
                    O_GPIO_OUT[gi] <= 1'b0;
                    O_GPIO_OE[gi]  <= 1'b0;
                end else begin
                    O_GPIO_OUT[gi] <= val_w ^ inv_w;
                    O_GPIO_OE[gi]  <= mode_w != ALRM_GPIO_OFF;
                end
            end

            property p_alert_pin;
                @(posedge I_CLK) disable iff (I_RST)
                mode_w == ALRM_GPIO_ALERT |=> O_GPIO_OUT[gi] == ($past(|(stk.sticky & alert_en_q) | |stk.blk_sticky) ^ $past(inv_w));
            endproperty
            a_alert_pin: assert property (p_alert_pin) else $error("alert pin not sticky-driven");

            property p_alert_neg;
                @(posedge I_CLK) disable iff (I_RST)
                mode_w == ALRM_GPIO_ALERT && !inv_w && stk.sticky == '0 && stk.blk_sticky == '0
                    ##1 mode_w == ALRM_GPIO_ALERT && !inv_w |-> !O_GPIO_OUT[gi];
            endproperty
            a_alert_neg: assert property (p_alert_neg) else $error("alert held after clear");

            property p_sigloss_live;
                @(posedge I_CLK) disable iff (I_RST)
                mode_w == ALRM_GPIO_SIGLOSS |=> O_GPIO_OUT[gi] == ($past(I_REF_SIG_LOSS[sel_w[1:0]]) ^ $past(inv_w));
            endproperty
            a_sigloss_live: assert property (p_sigloss_live) else $error("signal-loss pin not live");
        end
    endgenerate

    property p_bresp_follows;
        @(posedge I_CLK) disable iff (I_RST)
        aw_got_q && w_got_q && !O_BVALID |=> O_BVALID ##0 (O_BRESP == `ALRM_RESP_OKAY) == $past(wr_map_w);
    endproperty
    a_bresp_follows: assert property (p_bresp_follows) else $error("write response missing");

    property p_live_read;
        @(posedge I_CLK) disable iff (I_RST)
        ar_hs_w && I_ARADDR == `ALRM_ADDR_LIVE |=> O_RVALID && O_RDATA == {10'h0, $past(live_w)};
    endproperty
    a_live_read: assert property (p_live_read) else $error("live read not current");

    property p_locked_live;
        @(posedge I_CLK) disable iff (I_RST)
        !I_APLL_LOCKED |-> (live_w & 22'h2aa000) == 22'h000000;
    endproperty
    a_locked_live: assert property (p_locked_live) else $error("locked alarm without analog lock");

    property p_clr_clears;
        @(posedge I_CLK) disable iff (I_RST)
        wr_fire_w && wr_addr_q == `ALRM_ADDR_CLR && ctrl_q == 1'b0 && wr_strb_q == 4'hf
            |=> (stk.sticky & $past(wr_data_q[21:0])) == '0;
    endproperty
    a_clr_clears: assert property (p_clr_clears) else $error("clear write left bits set");
endmodule
`default_nettype wire

// *** alrm_cfg.svh ***
`ifndef ALRM_CFG_SVH
`define ALRM_CFG_SVH

`define ALRM_NUM_REF       4
`define ALRM_NUM_PLL       5
`define ALRM_NUM_ALM       22
`define ALRM_NUM_BLK       9
`define ALRM_NUM_GPIO      4
`define ALRM_PLL_BASE      12

`define ALRM_ADDR_CTRL     8'h00
`define ALRM_ADDR_LIVE     8'h04
`define ALRM_ADDR_STICKY   8'h08
`define ALRM_ADDR_CLR      8'h0c
`define ALRM_ADDR_ALERT_EN 8'h10
`define ALRM_ADDR_BLK_STK  8'h14
`define ALRM_ADDR_BLK_CLR  8'h18
`define ALRM_ADDR_PLL_ST   8'h1c
`define ALRM_ADDR_GPIO0    8'h20

`define ALRM_CTRL_GEN_BIT  0
`define ALRM_GCFG_MODE_LSB 0
`define ALRM_GCFG_INV_BIT  2
`define ALRM_GCFG_STK_BIT  3
`define ALRM_GCFG_SEL_LSB  4
`define ALRM_GCFG_W        9

`define ALRM_CTRL_RST      1'b1
`define ALRM_ALERT_EN_RST  22'h000000
`define ALRM_GCFG_RST      9'h000

`define ALRM_RESP_OKAY     2'b00
`define ALRM_RESP_SLVERR   2'b10

`endif

// *** alrm_pkg.sv ***
package alrm_pkg;
    typedef enum logic [1:0] {
        ALRM_GPIO_OFF     = 2'b00,
        ALRM_GPIO_ALERT   = 2'b01,
        ALRM_GPIO_SINGLE  = 2'b10,
        ALRM_GPIO_SIGLOSS = 2'b11
    } alrm_gmode_t;

    typedef enum logic [2:0] {
        ALRM_PLL_FREERUN  = 3'b000,
        ALRM_PLL_ACQUIRE  = 3'b001,
        ALRM_PLL_LOCKREC  = 3'b010,
        ALRM_PLL_LOCKED   = 3'b011,
        ALRM_PLL_HOLDOVER = 3'b100
    } alrm_pll_st_t;

    typedef logic [21:0] alrm_vec_t;
    typedef logic [8:0]  alrm_blk_t;
endpackage

// *** alrm_stk_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface alrm_stk_if;
    import alrm_pkg::*;
    alrm_vec_t live;
    alrm_vec_t clr;
    alrm_vec_t alert_en;
    alrm_blk_t blk_clr;
    logic      glob_en;
    alrm_vec_t sticky;
    alrm_blk_t blk_sticky;

    modport bank (input live, clr, alert_en, blk_clr, glob_en, output sticky, blk_sticky);
    modport ctl  (output live, clr, alert_en, blk_clr, glob_en, input sticky, blk_sticky);
endinterface
`default_nettype wire

// *** alrm_sticky_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "alrm_cfg.svh"
module alrm_sticky_bank import alrm_pkg::*; (
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    alrm_stk_if.bank   bus
);
    alrm_vec_t live_q;
    alrm_vec_t sticky_q;
    alrm_blk_t blk_q;
    alrm_vec_t set_w;
    alrm_vec_t stk_d;
    alrm_blk_t blk_set_w;

    function automatic alrm_blk_t blk_of(input alrm_vec_t v);
        alrm_blk_t b;
        b = '0;
        for (int r = 0; r < `ALRM_NUM_REF; r++) begin
            b[r] = |v[3*r +: 3];
        end
        for (int p = 0; p < `ALRM_NUM_PLL; p++) begin
            b[`ALRM_NUM_REF+p] = |v[`ALRM_PLL_BASE+2*p +: 2];
        end
        return b;
    endfunction

    // both edges of the live level count; nothing new latches while disabled
    assign set_w     = (bus.live ^ live_q) & {`ALRM_NUM_ALM{bus.glob_en}};
    assign stk_d     = set_w | (sticky_q & ~bus.clr);
    // level set: a block bit re-arms while any enabled member is still pending
    assign blk_set_w = blk_of(sticky_q & bus.alert_en);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            live_q   <= '0;
            sticky_q <= '0;
            blk_q    <= '0;
        end else begin
            live_q   <= bus.live;
            sticky_q <= stk_d;
            blk_q    <= blk_set_w | (blk_q & ~bus.blk_clr);
        end
    end

    assign bus.sticky     = sticky_q;
    assign bus.blk_sticky = blk_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_change_sets;
        bus.glob_en && (bus.live != live_q) |=> ((sticky_q & $past(bus.live ^ live_q)) == $past(bus.live ^ live_q));
    endproperty
    a_change_sets: assert property (p_change_sets) else $error("live change did not set sticky");

    property p_hold_until_clr;
        1'b1 |=> ((sticky_q & $past(sticky_q & ~bus.clr)) == $past(sticky_q & ~bus.clr));
    endproperty
    a_hold_until_clr: assert property (p_hold_until_clr) else $error("sticky dropped without clear");

    property p_set_wins;
        ((bus.live ^ live_q) & bus.clr) != '0 && bus.glob_en |=> ((sticky_q & $past(bus.clr & (bus.live ^ live_q))) != '0);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle set");

    property p_gated;
        !bus.glob_en |=> ((sticky_q & ~$past(sticky_q)) == '0);
    endproperty
    a_gated: assert property (p_gated) else $error("sticky set while alarms disabled");

    property p_blk_rearm;
        (blk_of(sticky_q & bus.alert_en) != '0) |=> ((blk_q & $past(blk_of(sticky_q & bus.alert_en))) != '0);
    endproperty
    a_blk_rearm: assert property (p_blk_rearm) else $error("block sticky not set by member");
endmodule
`default_nettype wire

// *** alrm_proc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module alrm_proc_model (
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    input  wire logic  i_alert,
    input  wire logic  i_inv,
    output logic       o_service,
    output logic [7:0] o_edge_q
);
    logic active;
    logic prev_q;
    assign active = i_alert ^ i_inv;
    // serviced on level: the pin may lag a clear, so edges are only counted
    assign o_service = active;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_q <= 1'b0;
            o_edge_q <= 8'h00;
        end else begin
            prev_q <= active;
            if (active && !prev_q) begin
                o_edge_q <= o_edge_q + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// *** alrm_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "alrm_cfg.svh"
module alrm_tb_top import alrm_pkg::*;;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  fa = 4'h0;
    logic [3:0]  sl = 4'h0;
    logic [3:0]  aa = 4'h0;
    logic [14:0] pst = 15'h0000;
    logic        apl = 1'b0;
    logic [7:0]  awa = 8'h00;
    logic [7:0]  ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        br = 1'b0;
    logic        arv = 1'b0;
    logic        rr = 1'b0;
    logic        inv = 1'b0;
    logic        awrdy, wrdy, bvld, arrdy, rvld, service;
    logic [1:0]  bre, rre;
    logic [31:0] rdat;
    logic [3:0]  gpio, oe;
    logic [7:0]  edges;
    int          fail_count = 0;
    int          n_tests = 0;

    always #2.5 clk = ~clk;

    alrm_top dut (.I_CLK(clk), .I_RST(rst), .I_REF_FREQ_ALM(fa), .I_REF_SIG_LOSS(sl), .I_REF_ACT_ALM(aa),
        .I_PLL_STATE(pst), .I_APLL_LOCKED(apl), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awrdy),
        .I_WDATA(wd), .I_WSTRB(4'hf), .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(bre), .O_BVALID(bvld),
        .I_BREADY(br), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arrdy), .O_RDATA(rdat), .O_RRESP(rre),
        .O_RVALID(rvld), .I_RREADY(rr), .O_GPIO_OUT(gpio), .O_GPIO_OE(oe));

    alrm_proc_model cpu (.i_clk(clk), .i_rst(rst), .i_alert(gpio[3]), .i_inv(inv), .o_service(service),
        .o_edge_q(edges));

    task automatic complete_run();
        $display("Checks %0d, errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic err(input string m);
        $display("Error at %0t: %s", $time, m);
        fail_count++;
    endtask

    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) err($sformatf("got %h expected %h", g, e));
    endtask

    // gives the registered pin path a few cycles to settle before judging
    task automatic chk_pin(input logic [7:0] e);
        int i;
        for (i = 0; i < 8; i++) begin
            if ({oe, gpio} === e) break;
            @(posedge clk);
        end
        n_tests++;
        if ({oe, gpio} !== e) err($sformatf("pins %h expected %h", {oe, gpio}, e));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // fx flips alarm inputs at the address take, so a live change meets the clear pulse
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00,
                          input logic [3:0] fx = 4'h0);
        int i;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (awv && awrdy) begin
                awv <= 1'b0;
                if (fx != 4'h0) fa <= fa ^ fx;
            end
            if (wv && wrdy) wv <= 1'b0;
            if (bvld) break;
        end
        br <= 1'b0;
        if (i == 100) begin
            err("write timeout");
            complete_run();
        end else begin
            chk_reg({30'h0, bre}, {30'h0, er});
        end
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
        int i;
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (arv && arrdy) arv <= 1'b0;
            if (rvld) break;
        end
        rr <= 1'b0;
        if (i == 100) begin
            err("read timeout");
            complete_run();
        end else begin
            chk_reg(rdat, e);
            chk_reg({30'h0, rre}, {30'h0, er});
        end
    endtask

    task automatic s_reset();
        bus_rd(`ALRM_ADDR_CTRL, 32'h1);
        bus_rd(`ALRM_ADDR_ALERT_EN, 32'h0);
        bus_rd(`ALRM_ADDR_STICKY, 32'h0);
        bus_rd(8'h40, 32'h0, `ALRM_RESP_SLVERR);
        bus_wr(8'h40, 32'h1, `ALRM_RESP_SLVERR);
        chk_pin(8'h00);
    endtask

    task automatic s_sticky();
        @(posedge clk);
        fa <= 4'h1;
        tick(2);
        bus_rd(`ALRM_ADDR_LIVE, 32'h1);
        bus_rd(`ALRM_ADDR_STICKY, 32'h1);
        bus_wr(`ALRM_ADDR_CLR, 32'h1);
        bus_rd(`ALRM_ADDR_STICKY, 32'h0);
        @(posedge clk);
        fa <= 4'h0;
        sl <= 4'h2;
        aa <= 4'h4;
        tick(2);
        bus_rd(`ALRM_ADDR_LIVE, 32'h110);
        bus_rd(`ALRM_ADDR_STICKY, 32'h111);
        bus_wr(`ALRM_ADDR_CLR, 32'h110);
        bus_rd(`ALRM_ADDR_STICKY, 32'h1);
        @(posedge clk);
        sl <= 4'h0;
        aa <= 4'h0;
        tick(2);
        bus_wr(`ALRM_ADDR_CLR, 32'h3fffff);
        bus_rd(`ALRM_ADDR_STICKY, 32'h0);
    endtask

    task automatic s_pll();
        @(posedge clk);
        pst <= 15'h0004;
        tick(2);
        bus_rd(`ALRM_ADDR_LIVE, 32'h1000);
        @(posedge clk);
        pst <= 15'h3003;
        apl <= 1'b1;
        tick(2);
        bus_rd(`ALRM_ADDR_LIVE, 32'h202000);
        bus_rd(`ALRM_ADDR_PLL_ST, 32'h3003);
        bus_rd(`ALRM_ADDR_STICKY, 32'h203000);
        @(posedge clk);
        apl <= 1'b0;
        tick(2);
        bus_rd(`ALRM_ADDR_LIVE, 32'h0);
        @(posedge clk);
        pst <= 15'h0000;
        bus_wr(`ALRM_ADDR_CLR, 32'h3fffff);
        bus_rd(`ALRM_ADDR_STICKY, 32'h0);
    endtask

    task automatic s_global();
        bus_wr(`ALRM_ADDR_CTRL, 32'h0);
        @(posedge clk);
        aa <= 4'h8;
        tick(2);
        bus_rd(`ALRM_ADDR_LIVE, 32'h800);
        bus_rd(`ALRM_ADDR_STICKY, 32'h0);
        @(posedge clk);
        aa <= 4'h0;
        tick(2);
        bus_wr(`ALRM_ADDR_CLR, 32'h3fffff);
        bus_wr(`ALRM_ADDR_CTRL, 32'h1);
        bus_rd(`ALRM_ADDR_STICKY, 32'h0);
    endtask

    task automatic s_set_wins();
        bus_wr(`ALRM_ADDR_CLR, 32'h1, `ALRM_RESP_OKAY, 4'h1);
        bus_rd(`ALRM_ADDR_STICKY, 32'h1);
        @(posedge clk);
        fa <= 4'h0;
        tick(2);
        bus_wr(`ALRM_ADDR_CLR, 32'h3fffff);
        bus_rd(`ALRM_ADDR_STICKY, 32'h0);
    endtask

    task automatic s_gpio();
        bus_wr(`ALRM_ADDR_ALERT_EN, 32'h1);
        bus_wr(`ALRM_ADDR_GPIO0, 32'h002);
        bus_wr(`ALRM_ADDR_GPIO0 + 8'h04, 32'h01e);
        bus_wr(`ALRM_ADDR_GPIO0 + 8'h08, 32'h023);
        bus_wr(`ALRM_ADDR_GPIO0 + 8'h0c, 32'h001);
        chk_pin(8'hf2);
        @(posedge clk);
        sl <= 4'h5;
        chk_pin(8'hf4);
        @(posedge clk);
        sl <= 4'h1;
        chk_pin(8'hf0);
        @(posedge clk);
        fa <= 4'h1;
        chk_pin(8'hf9);
        chk_reg({31'h0, service}, 32'h1);
        @(posedge clk);
        fa <= 4'h0;
        chk_pin(8'hf8);
        // individual stickies first so the block bit is not set again
        bus_wr(`ALRM_ADDR_CLR, 32'h3);
        tick(4);
        chk_pin(8'hfa);
        bus_rd(`ALRM_ADDR_BLK_STK, 32'h1);
        bus_wr(`ALRM_ADDR_BLK_CLR, 32'h1);
        chk_pin(8'hf2);
        bus_rd(`ALRM_ADDR_BLK_STK, 32'h0);
        bus_wr(`ALRM_ADDR_GPIO0 + 8'h0c, 32'h005);
        inv <= 1'b1;
        chk_pin(8'hfa);
        chk_reg({31'h0, service}, 32'h0);
        chk_reg({24'h0, edges}, 32'h1);
    endtask

    initial begin
        tick(2);
        rst <= 1'b0;
        tick(2);
        s_reset();
        s_sticky();
        s_pll();
        s_global();
        s_set_wins();
        s_gpio();
        complete_run();
    end
endmodule
`default_nettype wire
